/* File: sbc_map.svh */
`ifndef SBC_MAP_SVH
`define SBC_MAP_SVH

// Request field widths, counter width and class count
`define SBC_ADDR_W        32
`define SBC_ID_W          8
`define SBC_SNOOP_W       4
`define SBC_DOM_W         2
`define SBC_CNT_W         16
`define SBC_NUM_CLASS     3

// Shareability domain encodings
`define SBC_DOM_NSH       2'h0
`define SBC_DOM_INNER     2'h1
`define SBC_DOM_OUTER     2'h2
`define SBC_DOM_SYS       2'h3

// Snoop encodings
`define SBC_SNP_NOSNOOP   4'h0
`define SBC_SNP_LINEUNIQ  4'h1
`define SBC_SNP_CLEANSHR  4'h8
`define SBC_SNP_CLEANINV  4'h9
`define SBC_SNP_MAKEINV   4'hd

// Class indices for the statistics counters
`define SBC_CLS_INNER     0
`define SBC_CLS_OUTER     1
`define SBC_CLS_CMO       2

// Counter reset value and increment
`define SBC_CNT_RST       16'h0000
`define SBC_CNT_ONE       16'h0001

`endif

/* File: sbc_pkg.sv */
`include "sbc_map.svh"

package sbc_pkg;

  typedef struct packed {
    logic                     inner;
    logic                     outer;
    logic                     cmaint;
  } sbc_cfg_s;

  typedef struct packed {
    logic                     wr;
    logic [`SBC_ID_W-1:0]     id;
    logic [`SBC_ADDR_W-1:0]   addr;
    logic [`SBC_SNOOP_W-1:0]  snoop;
    logic                     bar;
    logic [`SBC_DOM_W-1:0]    domain;
  } sbc_req_s;

  typedef enum logic [1:0] {
    SBC_KIND_PLAIN,
    SBC_KIND_INNER,
    SBC_KIND_OUTER,
    SBC_KIND_CMO
  } sbc_kind_e;

  typedef struct packed {
    sbc_req_s                 req;
    sbc_kind_e                kind;
    logic                     bcast;
    logic                     local_cmo;
  } sbc_dec_s;

endpackage : sbc_pkg

/* File: sbc_class.sv */
`timescale 1ns/1ps
`include "sbc_map.svh"

module sbc_class
  import sbc_pkg::*;
(
  input  wire sbc_req_s in_req,
  input  wire sbc_cfg_s cfg,
  output sbc_dec_s      dec
);

  logic inner_ok;
  logic is_cmo;

  always_comb begin
    inner_ok      = cfg.inner & cfg.outer;                         // see RL2
    is_cmo        = ~in_req.wr & ~in_req.bar &
                    ((in_req.snoop == `SBC_SNP_CLEANSHR) ||
                     (in_req.snoop == `SBC_SNP_CLEANINV) ||
                     (in_req.snoop == `SBC_SNP_MAKEINV));
    dec           = '0;
    dec.req       = in_req;
    dec.kind      = SBC_KIND_PLAIN;
    dec.bcast     = 1'b0;
    dec.local_cmo = 1'b0;
    if (in_req.bar) begin
      dec.kind = SBC_KIND_PLAIN;
    end else if (is_cmo) begin
      dec.kind = SBC_KIND_CMO;
      if (cfg.cmaint) begin
        dec.bcast = 1'b1;                                          // see RL5, see RL7
      end else begin
        case (in_req.domain)                                       // see RL8
          `SBC_DOM_INNER: dec.bcast = inner_ok;
          `SBC_DOM_OUTER: dec.bcast = cfg.outer;
          default:        dec.bcast = 1'b0;
        endcase
      end
      dec.local_cmo = ~dec.bcast;                                  // see RL5
    end else if (in_req.domain == `SBC_DOM_INNER) begin
      dec.kind  = SBC_KIND_INNER;
      dec.bcast = inner_ok;                                        // see RL3, see RL9
    end else if (in_req.domain == `SBC_DOM_OUTER) begin
      dec.kind  = SBC_KIND_OUTER;
      dec.bcast = cfg.outer;                                       // see RL4, see RL9
    end
    if ((dec.kind == SBC_KIND_INNER || dec.kind == SBC_KIND_OUTER) && !dec.bcast) begin
      dec.req.snoop  = `SBC_SNP_NOSNOOP;                           // see RL10
      dec.req.domain = `SBC_DOM_NSH;                               // see RL10
    end
  end

endmodule : sbc_class

/* File: sbc_top.sv */
`timescale 1ns/1ps
`include "sbc_map.svh"

// Behaviour
// RL1 - Integrator keeps enable inputs static through reset
// RL2 - Inner enable is only valid with outer
// RL3 - Inner shareable broadcast only when inner enabled
// RL4 - Outer shareable broadcast only when outer enabled
// RL5 - Maintenance enable decides maintenance issue onto interconnect
// RL6 - Integrator sets maintenance enable with downstream cache
// RL7 - Maintenance enabled: broadcast all maintenance operations
// RL8 - Maintenance disabled: domain and enables decide
// RL9 - Enable triple maps to broadcast classes
// RL10 - Unbroadcast shareable requests become non-snooping
module sbc_top
  import sbc_pkg::*;
(
  input  wire logic     clk,
  input  wire logic     rst,
  input  wire logic     inner_shareable_bcast_en,
  input  wire logic     outer_shareable_bcast_en,
  input  wire logic     cache_maint_bcast_en,
  input  wire logic     up_valid,
  input  wire sbc_req_s up_req,
  output logic          up_ready,
  output logic          dn_valid,
  output sbc_req_s      dn_req,
  output logic          dn_bcast,
  input  wire logic     dn_ready,
  output logic          cmo_local_done,
  output logic [`SBC_ID_W-1:0] cmo_local_id,
  output logic          cmo_local_wr,
  output logic          cfg_invalid,
  output logic [`SBC_NUM_CLASS-1:0][`SBC_CNT_W-1:0] bcast_cnt,
  output logic [`SBC_NUM_CLASS-1:0][`SBC_CNT_W-1:0] filt_cnt
);

  typedef struct packed {
    sbc_cfg_s                                      cfg;
    logic                                          cfg_bad;
    logic                                          up_ready;
    logic                                          dn_valid;
    sbc_req_s                                      dn_req;
    logic                                          dn_bcast;
    logic                                          cmo_done;
    logic [`SBC_ID_W-1:0]                          cmo_id;
    logic                                          cmo_wr;
    logic [`SBC_NUM_CLASS-1:0][`SBC_CNT_W-1:0]     bcast_cnt;
    logic [`SBC_NUM_CLASS-1:0][`SBC_CNT_W-1:0]     filt_cnt;
  } sbc_state_s;

  sbc_state_s st;
  sbc_state_s next_st;
  sbc_dec_s   dec;
  logic       take;
  logic       drain;
  int         cls;

  // Classifier works on the configuration captured at reset
  sbc_class u_class (
    .in_req (up_req),
    .cfg    (st.cfg),
    .dec    (dec)
  );

  always_comb begin
    next_st          = st;
    take             = up_valid & st.up_ready;
    drain            = st.dn_valid & dn_ready;
    cls              = `SBC_CLS_INNER;
    next_st.cmo_done = 1'b0;

    if (rst) begin
      // Enables are static tie-offs, sampled while reset is held
      next_st.cfg.inner  = inner_shareable_bcast_en;               // see RL1
      next_st.cfg.outer  = outer_shareable_bcast_en;               // see RL1
      next_st.cfg.cmaint = cache_maint_bcast_en;                   // see RL1
      next_st.cfg_bad    = inner_shareable_bcast_en &
                           ~outer_shareable_bcast_en;              // see RL2
      next_st.up_ready   = 1'b0;
      next_st.dn_valid   = 1'b0;
      next_st.dn_req     = '0;
      next_st.dn_bcast   = 1'b0;
      next_st.cmo_done   = 1'b0;
      next_st.cmo_id     = '0;
      next_st.cmo_wr     = 1'b0;
      for (int i = 0; i < `SBC_NUM_CLASS; i++) begin
        next_st.bcast_cnt[i] = `SBC_CNT_RST;
        next_st.filt_cnt[i]  = `SBC_CNT_RST;
      end
    end else begin
      if (drain) begin
        next_st.dn_valid = 1'b0;
      end

      if (take) begin
        if (dec.local_cmo) begin
          // Maintenance kept off the interconnect completes here
          next_st.cmo_done = 1'b1;                                 // see RL5, see RL8
          next_st.cmo_id   = up_req.id;
          next_st.cmo_wr   = up_req.wr;
        end else begin
          next_st.dn_valid = 1'b1;
          next_st.dn_req   = dec.req;                              // see RL10
          next_st.dn_bcast = dec.bcast;                            // see RL9
        end

        case (dec.kind)
          SBC_KIND_INNER: cls = `SBC_CLS_INNER;
          SBC_KIND_OUTER: cls = `SBC_CLS_OUTER;
          SBC_KIND_CMO:   cls = `SBC_CLS_CMO;
          default:        cls = `SBC_CLS_INNER;
        endcase

        if (dec.kind != SBC_KIND_PLAIN) begin
          if (dec.bcast) begin
            next_st.bcast_cnt[cls] = st.bcast_cnt[cls] + `SBC_CNT_ONE;
          end else begin
            next_st.filt_cnt[cls] = st.filt_cnt[cls] + `SBC_CNT_ONE;
          end
        end
      end

      // Accept only into an empty output slot
      next_st.up_ready = ~next_st.dn_valid;
    end
  end

  always_ff @(posedge clk) begin
    st <= next_st;
  end

  assign up_ready       = st.up_ready;
  assign dn_valid       = st.dn_valid;
  assign dn_req         = st.dn_req;
  assign dn_bcast       = st.dn_bcast;
  assign cmo_local_done = st.cmo_done;
  assign cmo_local_id   = st.cmo_id;
  assign cmo_local_wr   = st.cmo_wr;
  assign cfg_invalid    = st.cfg_bad;
  assign bcast_cnt      = st.bcast_cnt;
  assign filt_cnt       = st.filt_cnt;

endmodule : sbc_top

/* File: sbc_chk_sva.sv */
`timescale 1ns/1ps
`include "sbc_map.svh"
module sbc_chk
  import sbc_pkg::*;
(
  input wire logic     clk,
  input wire logic     rst,
  input wire logic     inner_shareable_bcast_en,
  input wire logic     outer_shareable_bcast_en,
  input wire logic     cache_maint_bcast_en,
  input wire logic     up_valid,
  input wire sbc_req_s up_req,
  input wire logic     up_ready,
  input wire logic     dn_valid,
  input wire sbc_req_s dn_req,
  input wire logic     dn_bcast,
  input wire logic     dn_ready,
  input wire logic     cmo_local_done,
  input wire logic     cfg_invalid
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire logic io = inner_shareable_bcast_en && outer_shareable_bcast_en;
  wire logic oo = outer_shareable_bcast_en;
  wire logic cm = cache_maint_bcast_en;
  wire logic tk = up_valid && up_ready && !up_req.bar;
  wire logic m  = !up_req.wr && up_req.snoop[3];
  chk_strap_flag: assert property (
      cfg_invalid == (inner_shareable_bcast_en && !oo))
    else $error("invalid strap flag wrong");
  chk_inner_gate: assert property (
      tk && !m && up_req.domain == `SBC_DOM_INNER |=> dn_bcast == io)
    else $error("inner broadcast wrong");
  chk_outer_gate: assert property (
      tk && !m && up_req.domain == `SBC_DOM_OUTER |=> dn_bcast == oo)
    else $error("outer broadcast wrong");
  chk_take_answer: assert property (up_valid && up_ready |=> dn_valid != cmo_local_done)
    else $error("request answered wrongly");
  chk_cmo_all: assert property (tk && m && cm |=> dn_valid && dn_bcast)
    else $error("maintenance not broadcast");
  chk_cmo_domain: assert property (
      tk && m && !cm && up_req.domain == `SBC_DOM_INNER |=> dn_valid == io)
    else $error("maintenance domain decision wrong");
  chk_local_only: assert property (cmo_local_done |-> !cm)
    else $error("local completion while broadcast on");
  chk_nosnoop_form: assert property (
      dn_valid && !dn_bcast && !dn_req.bar |->
      dn_req.domain inside {`SBC_DOM_NSH, `SBC_DOM_SYS})
    else $error("unbroadcast request kept shareable");
  chk_hold_req: assert property (
      dn_valid && !dn_ready |=> dn_valid && $stable(dn_req) && $stable(dn_bcast))
    else $error("pending request changed");
endmodule : sbc_chk

/* File: sbc_icm.sv */
`timescale 1ns/1ps
module sbc_icm #(parameter int SEED = 7) (
  input  wire logic clk,
  output logic      dn_ready
);
  integer s = SEED;
  initial dn_ready = 1'b0;
  // Accepts at random, stalling about one edge in three
  always @(posedge clk) dn_ready <= #1 ($random(s) % 3 != 0);
endmodule : sbc_icm

/* File: test_shareable_broadcast_control.sv */
`timescale 1ns/1ps
`include "sbc_map.svh"
module test_shareable_broadcast_control;
  import sbc_pkg::*;
  logic     clk = 1'b0, rst = 1'b1, up_valid = 1'b0, sh_i = 1'b0, sh_o = 1'b0, cm = 1'b0;
  sbc_req_s up_req = '0, r;
  wire logic up_ready, dn_valid, dn_bcast, dn_ready, cmo_local_done, cfg_invalid;
  wire sbc_req_s dn_req;
  wire logic [`SBC_ID_W-1:0] cmo_local_id;
  wire logic cmo_local_wr;
  wire logic [`SBC_NUM_CLASS-1:0][`SBC_CNT_W-1:0] bcast_cnt, filt_cnt;
  logic [`SBC_NUM_CLASS-1:0][`SBC_CNT_W-1:0] exp_bc, exp_fc;
  integer   seed = 32'hf20c, bad_count = 0, n_tests = 0;
  logic [2:0] cfgs [7] = '{3'h0, 3'h2, 3'h6, 3'h1, 3'h3, 3'h7, 3'h4};
  logic [3:0] snp [4] = '{`SBC_SNP_NOSNOOP, `SBC_SNP_CLEANSHR, `SBC_SNP_CLEANINV, `SBC_SNP_MAKEINV};
  always #12.5 clk = ~clk;
  sbc_top dut_u (.clk, .rst, .inner_shareable_bcast_en(sh_i), .outer_shareable_bcast_en(sh_o),
    .cache_maint_bcast_en(cm), .up_valid, .up_req, .up_ready, .dn_valid, .dn_req, .dn_bcast,
    .dn_ready, .cmo_local_done, .cmo_local_id, .cmo_local_wr, .cfg_invalid, .bcast_cnt,
    .filt_cnt);
  sbc_icm icm_u (.clk, .dn_ready);
  task automatic chk(input logic [48:0] seen, input logic [48:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic give_verdict;
    if (bad_count == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict
  // Returns forwarded and broadcast flags
  function automatic logic [1:0] exp_f(sbc_req_s q);
    logic b;
    b = (q.domain == `SBC_DOM_INNER) ? sh_i && sh_o : (q.domain == `SBC_DOM_OUTER) && sh_o;
    if (q.bar) return 2'b10;
    if (!q.wr && q.snoop[3]) return {cm | b, cm | b};
    return {1'b1, b};
  endfunction : exp_f
  task automatic send(input sbc_req_s q);
    logic [1:0] f;
    sbc_req_s   e;
    int         n;
    int         c;
    f = exp_f(q);
    e = q;
    n = 0;
    c = (!q.wr && q.snoop[3]) ? `SBC_CLS_CMO :
        (q.domain == `SBC_DOM_OUTER) ? `SBC_CLS_OUTER : `SBC_CLS_INNER;
    if (!q.bar && (c == `SBC_CLS_CMO || q.domain inside {`SBC_DOM_INNER, `SBC_DOM_OUTER})) begin
      if (f[0]) exp_bc[c] += `SBC_CNT_ONE;
      else exp_fc[c] += `SBC_CNT_ONE;
    end
    if (!f[0] && !q.bar && q.domain inside {`SBC_DOM_INNER, `SBC_DOM_OUTER}) begin
      e.snoop = `SBC_SNP_NOSNOOP;
      e.domain = `SBC_DOM_NSH;
    end
    up_req = q;
    up_valid = 1'b1;
    while (up_ready !== 1'b1 && n < 40) begin
      @(posedge clk);
      #1;
      n++;
    end
    @(posedge clk);
    #1;
    chk(dn_valid, f[1]);
    chk(cmo_local_done, !f[1]);
    if (f[1]) chk({dn_bcast, dn_req}, {f[0], e});
    else begin
      chk(cmo_local_id, q.id);
      chk(cmo_local_wr, q.wr);
    end
    chk(bcast_cnt, exp_bc);
    chk(filt_cnt, exp_fc);
  endtask : send
  initial begin
    for (int k = 0; k < 7; k++) begin
      {sh_i, sh_o, cm} = cfgs[k];
      rst = 1'b1;
      up_valid = 1'b0;
      exp_bc = '0;
      exp_fc = '0;
      repeat (10) @(posedge clk);
      #1;
      rst = 1'b0;
      chk(cfg_invalid, sh_i && !sh_o);
      for (int i = 0; i < 40; i++) begin
        r = 48'({$random(seed), $random(seed)});
        r.snoop = r.wr ? {3'h0, r.snoop[0]} : snp[r.snoop[1:0]];
        r.bar = (r.addr[2:0] == 3'h0);
        if (r.bar) r.snoop = `SBC_SNP_NOSNOOP;
        if (r.snoop[3] && &r.domain) r.domain = `SBC_DOM_NSH;
        if (i < 3) begin
          r.wr = 1'b0;
          r.bar = 1'b0;
          r.snoop = `SBC_SNP_MAKEINV;
          r.domain = i[1:0];
        end
        send(r);
      end
    end
    give_verdict();
  end
  initial begin
    #400000;
    bad_count++;
    give_verdict();
  end
endmodule : test_shareable_broadcast_control
bind sbc_top sbc_chk chk_u (
  .clk                      (clk),
  .rst                      (rst),
  .inner_shareable_bcast_en (inner_shareable_bcast_en),
  .outer_shareable_bcast_en (outer_shareable_bcast_en),
  .cache_maint_bcast_en     (cache_maint_bcast_en),
  .up_valid                 (up_valid),
  .up_req                   (up_req),
  .up_ready                 (up_ready),
  .dn_valid                 (dn_valid),
  .dn_req                   (dn_req),
  .dn_bcast                 (dn_bcast),
  .dn_ready                 (dn_ready),
  .cmo_local_done           (cmo_local_done),
  .cfg_invalid              (cfg_invalid)
);
